/* rtl/fdr_pkg.sv */
package fdr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_SEC = 1_000_000_000;
    localparam int SEC_CYCLES = NS_PER_SEC / CLK_PERIOD_NS;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_57600 = 57600;
    localparam logic [15:0] DIV_9600 = 16'(NS_PER_SEC / (CLK_PERIOD_NS * BAUD_9600));
    localparam logic [15:0] DIV_19200 = 16'(NS_PER_SEC / (CLK_PERIOD_NS * BAUD_19200));
    localparam logic [15:0] DIV_57600 = 16'(NS_PER_SEC / (CLK_PERIOD_NS * BAUD_57600));

    // ------------------------------------------------------------
    // Holding and input register numbers
    // ------------------------------------------------------------
    localparam logic [6:0] HR_RESET = 7'h00;
    localparam logic [6:0] HR_MIN_RPM = 7'h01;
    localparam logic [6:0] HR_MAX_RPM = 7'h02;
    localparam logic [6:0] HR_CURRENT = 7'h07;
    localparam logic [6:0] HR_FIXED_SPD = 7'h15;
    localparam logic [6:0] HR_FB_POL = 7'h1F;
    localparam logic [6:0] HR_SKIP_LO = 7'h20;
    localparam logic [6:0] HR_SKIP_HI = 7'h21;
    localparam logic [6:0] HR_MODE = 7'h22;
    localparam logic [6:0] HR_COAST = 7'h23;
    localparam logic [6:0] HR_POWER = 7'h24;
    localparam logic [6:0] HR_NODE_ID = 7'h2D;
    localparam logic [6:0] HR_PIN_FUNC = 7'h2E;
    localparam logic [6:0] HR_BIT_RATE = 7'h2F;
    localparam logic [6:0] HR_FRAMING = 7'h30;
    localparam logic [6:0] HR_LOOP_REF = 7'h32;
    localparam logic [6:0] HR_KP = 7'h33;
    localparam logic [6:0] HR_KI = 7'h34;
    localparam logic [6:0] HR_KD = 7'h35;
    localparam logic [6:0] HR_SAMPLE = 7'h36;
    localparam logic [6:0] HR_RPM_ALARM = 7'h37;
    localparam logic [6:0] HR_LINK_TMO = 7'h38;
    localparam logic [6:0] HR_VOL_SP = 7'h42;
    localparam logic [6:0] IR_SPEED_REF = 7'h02;
    localparam logic [6:0] IR_SPEED_MEAS = 7'h03;
    localparam logic [6:0] BOOT_LAST = 7'h3F;

    // ------------------------------------------------------------
    // Protocol codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] NODE_BROADCAST = 8'h00;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SKIP = 16'h4E20;
    localparam logic [15:0] RST_MODE = 16'h0001;
    localparam logic [15:0] RST_COAST = 16'h4E20;
    localparam logic [15:0] RST_NODE_ID = 16'h0001;
    localparam logic [15:0] RATE_9600 = 16'h2580;
    localparam logic [15:0] RATE_19200 = 16'h4B00;
    localparam logic [15:0] RPM_CEIL = 16'h4E20;
    localparam logic [15:0] TMO_MAX = 16'h7FFF;
    localparam logic [15:0] NODE_MAX = 16'h00F7;
    localparam logic [15:0] MODE_MAX = 16'h000C;
    localparam logic [15:0] FRAMING_MAX = 16'h0002;
    localparam logic [15:0] POWER_MIN = 16'h000A;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [15:0] MODE_FIXED = 16'h0002;
    localparam logic [7:0] LOCAL_NODE = 8'h01;
    localparam logic [1:0] LOCAL_FRAMING = 2'h0;
    localparam logic [4:0] KHZ_LOW_SPEED = 5'h0E;
    localparam logic [4:0] KHZ_HIGH_SPEED = 5'h08;

    typedef enum logic [1:0] {
        ST_BOOT_RD = 2'b00,
        ST_BOOT_WR = 2'b01,
        ST_IDLE = 2'b10,
        ST_READ = 2'b11
    } fdr_state_t;

endpackage

/* rtl/fdr_word_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module fdr_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
)(
    input wire logic clk_sys,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_ff
);
    // No reset: contents must outlive a reset, as stored settings do
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (wrEn)
        begin
            store[wrAddr] <= wrData;
        end
        rdData_ff <= store[rdAddr];
    end
endmodule
`default_nettype wire

/* rtl/fdr_link_watch.sv */
`timescale 1ns/1ps
`default_nettype none
module fdr_link_watch #(
    parameter int CYC_PER_SEC = fdr_pkg::SEC_CYCLES,
    parameter int SEC_W = 15
)(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [SEC_W-1:0] limitSec,
    input wire logic activity,
    input wire logic restart,
    output logic expired_ff
);
    import fdr_pkg::*;
    localparam int CW = $clog2(CYC_PER_SEC + 1);
    logic [CW-1:0] tick_ff;
    logic [SEC_W-1:0] secs_ff;
    logic tickEnd;
    logic [SEC_W-1:0] secsNext;
    logic idle;

    assign tickEnd = tick_ff == CW'(CYC_PER_SEC - 1);
    assign secsNext = secs_ff + SEC_W'(1);
    // Zero limit disables the watch altogether
    assign idle = srst | activity | restart | (limitSec == '0);

    always_ff @(posedge clk_sys)
    begin
        if (idle)
        begin
            tick_ff <= '0;
            secs_ff <= '0;
            expired_ff <= 1'b0;
        end
        else if (!expired_ff)
        begin
            tick_ff <= tickEnd ? '0 : tick_ff + CW'(1);
            if (tickEnd)
            begin
                secs_ff <= secsNext;
                expired_ff <= secsNext == limitSec;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/fdr_holding_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Switching runs 14 kHz at low speed, 8 kHz at high speed.
// - Out-of-range writes leave the register unchanged, never clamped.
// - Register 47 picks RS-485 rate; only 9600 or 19200 allowed.
// - Register 48 framing: 0 none/2 stop, 1 odd/1, 2 even/1.
// - Rate and framing registers affect RS-485 only; local port fixed.
// - Serve read holding, read input and write single register.
// - Writes other than framing and node act at once, even running, and never reach storage then.
// - Register 56 sets link-loss seconds; expiry stops fan; zero disables.
// - Slave node number comes from register 45, range 1 to 247.
// - Frames to node 0 are accepted as broadcasts.
// - Factory RS-485 settings: 9600, framing 0, node 1.
// - Local service port uses 57600, framing 0, node 1.
// - Rate change is immediate; framing and node wait for power cycle.
// - Register 66 is a write-only volatile setpoint.
// - Sixty-four stored registers, twenty-three user writable.
// - Writing 1 to register 0 clears faults, restarts, reads back 0.
// - Register 1 minimum speed ranges from model default to maximum.
// - Mode 2 takes its speed setpoint from register 21.
module fdr_holding_bank #(
    parameter logic [15:0] MIN_RPM_DEF = 16'h0096,
    parameter logic [15:0] MAX_RPM_DEF = 16'h0D16,
    parameter logic [15:0] CURRENT_DEF = 16'h1770,
    parameter logic [15:0] POWER_DEF = 16'h0546,
    parameter logic [15:0] SWITCH_RPM = 16'h03E8,
    parameter int CYC_PER_SEC = fdr_pkg::SEC_CYCLES
)(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic factoryRestore,
    input wire logic reqValid,
    input wire logic reqPort,
    input wire logic [7:0] reqNode,
    input wire logic [7:0] reqFunc,
    input wire logic [15:0] reqReg,
    input wire logic [15:0] reqData,
    input wire logic motorRunning,
    input wire logic [15:0] measuredRpm,
    input wire logic [15:0] analogSetpoint,
    output logic reqReady_ff,
    output logic rspValid_ff,
    output logic rspException_ff,
    output logic rspPort_ff,
    output logic [7:0] rspCode_ff,
    output logic [15:0] rspData_ff,
    output logic faultClear_ff,
    output logic fanStop_ff,
    output logic [15:0] speedSetpoint_ff,
    output logic [3:0] opMode_ff,
    output logic [4:0] switchKhz_ff,
    output logic [15:0] rs485BitDiv_ff,
    output logic [1:0] rs485Framing_ff,
    output logic [7:0] rs485Node_ff,
    output logic [15:0] localBitDiv_ff,
    output logic [1:0] localFraming_ff,
    output logic [7:0] localNode_ff
);
    import fdr_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic userReg(input logic [6:0] idx);
        case (idx)
            HR_RESET, HR_MIN_RPM, HR_MAX_RPM, HR_CURRENT, HR_FIXED_SPD,
            HR_FB_POL, HR_SKIP_LO, HR_SKIP_HI, HR_MODE, HR_COAST, HR_POWER,
            HR_NODE_ID, HR_PIN_FUNC, HR_BIT_RATE, HR_FRAMING, HR_LOOP_REF,
            HR_KP, HR_KI, HR_KD, HR_SAMPLE, HR_RPM_ALARM, HR_LINK_TMO,
            HR_VOL_SP: userReg = 1'b1;
            default: userReg = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] factoryValue(input logic [6:0] idx);
        case (idx)
            HR_MIN_RPM: factoryValue = MIN_RPM_DEF;
            HR_MAX_RPM: factoryValue = MAX_RPM_DEF;
            HR_CURRENT: factoryValue = CURRENT_DEF;
            HR_SKIP_LO, HR_SKIP_HI: factoryValue = RST_SKIP;
            HR_MODE: factoryValue = RST_MODE;
            HR_COAST: factoryValue = RST_COAST;
            HR_POWER: factoryValue = POWER_DEF;
            HR_NODE_ID: factoryValue = RST_NODE_ID;
            HR_BIT_RATE: factoryValue = RATE_9600;
            default: factoryValue = RST_ZERO;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fdr_state_t state_ff;
    fdr_state_t nxt_state;
    logic [6:0] bootIdx_ff;
    logic [15:0] minRpm_ff;
    logic [15:0] maxRpm_ff;
    logic [15:0] skipLo_ff;
    logic [15:0] skipHi_ff;
    logic [15:0] fixedSpd_ff;
    logic [15:0] mode_ff;
    logic [15:0] linkTmo_ff;
    logic [15:0] volSp_ff;
    logic curPort_ff;
    logic [15:0] liveRdData;
    logic [15:0] nvmRdData;
    logic linkExpired;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic [6:0] reqIdx;
    logic reqHi;
    logic [7:0] ownNode;
    logic isBcast;
    logic nodeHit;
    logic take;
    logic isUser;
    logic inRange;
    logic wrOk;
    logic holdReadable;
    logic readHoldOk;
    logic inputOk;
    logic bootWr;
    logic [15:0] bootWord;
    logic [15:0] storeWord;
    logic loadEn;
    logic [6:0] loadIdx;
    logic [15:0] loadWord;
    logic nvmWrEn;
    logic directRsp;
    logic directExc;
    logic [7:0] excCode;
    logic [15:0] directData;
    logic [15:0] rateDiv;
    logic [15:0] setpointSel;
    logic modeTemp;

    assign reqIdx = reqReg[6:0];
    assign reqHi = |reqReg[15:7];
    assign ownNode = reqPort ? localNode_ff : rs485Node_ff;
    assign isBcast = reqNode == NODE_BROADCAST;
    assign nodeHit = isBcast | (reqNode == ownNode);
    assign take = reqValid & reqReady_ff & nodeHit;
    assign isUser = !reqHi & userReg(reqIdx);
    assign holdReadable = isUser & (reqIdx != HR_VOL_SP);

    // Limits that depend on other registers use the live shadow copies
    always_comb
    begin
        case (reqIdx)
            HR_RESET: inRange = reqData <= ONE;
            HR_MIN_RPM: inRange = reqData >= MIN_RPM_DEF && reqData <= maxRpm_ff;
            HR_MAX_RPM: inRange = reqData >= minRpm_ff && reqData <= MAX_RPM_DEF;
            HR_CURRENT: inRange = reqData >= ONE && reqData <= CURRENT_DEF;
            HR_FIXED_SPD: inRange = reqData >= minRpm_ff && reqData <= maxRpm_ff;
            HR_FB_POL: inRange = reqData <= ONE;
            HR_SKIP_LO: inRange = reqData <= skipHi_ff;
            HR_SKIP_HI: inRange = reqData >= skipLo_ff && reqData <= RPM_CEIL;
            HR_MODE: inRange = reqData <= MODE_MAX;
            HR_COAST: inRange = reqData <= RPM_CEIL;
            HR_POWER: inRange = reqData >= POWER_MIN && reqData <= POWER_DEF;
            HR_NODE_ID: inRange = reqData >= ONE && reqData <= NODE_MAX;
            HR_BIT_RATE: inRange = reqData == RATE_9600 || reqData == RATE_19200;
            HR_FRAMING: inRange = reqData <= FRAMING_MAX;
            HR_LINK_TMO: inRange = reqData <= TMO_MAX;
            default: inRange = 1'b1;
        endcase
    end

    // Writes are taken regardless of motor state
    assign wrOk = take & (reqFunc == FC_WRITE_ONE) & isUser & inRange;
    assign readHoldOk = take & !isBcast & (reqFunc == FC_READ_HOLD) & holdReadable;
    assign inputOk = !reqHi & (reqIdx == IR_SPEED_REF || reqIdx == IR_SPEED_MEAS);

    // ------------------------------------------------------------
    // Load path shared by boot copy and accepted writes
    // ------------------------------------------------------------
    assign bootWr = state_ff == ST_BOOT_WR;
    assign bootWord = factoryRestore ? factoryValue(bootIdx_ff) : nvmRdData;
    assign storeWord = (reqIdx == HR_RESET) ? RST_ZERO : reqData;
    assign loadEn = bootWr | wrOk;
    assign loadIdx = bootWr ? bootIdx_ff : reqIdx;
    assign loadWord = bootWr ? bootWord : storeWord;
    // Running-motor writes stay volatile; the register 66 word has no store slot
    assign nvmWrEn = (bootWr & factoryRestore) | (wrOk & !motorRunning & !reqIdx[6]);

    always_comb
    begin
        case (loadWord)
            RATE_19200: rateDiv = DIV_19200;
            default: rateDiv = DIV_9600;
        endcase
    end

    // ------------------------------------------------------------
    // Direct answers (writes, input reads, errors)
    // ------------------------------------------------------------
    assign directRsp = take & !isBcast & !readHoldOk;
    assign directExc = (reqFunc == FC_WRITE_ONE) ? !wrOk :
                       (reqFunc == FC_READ_INPUT) ? !inputOk : 1'b1;
    assign excCode = (reqFunc == FC_WRITE_ONE) ? (isUser ? EXC_VALUE : EXC_ADDR) :
                     (reqFunc == FC_READ_HOLD || reqFunc == FC_READ_INPUT) ? EXC_ADDR :
                     EXC_FUNC;
    assign directData = directExc ? {8'h00, excCode} :
                        (reqFunc == FC_WRITE_ONE) ? reqData :
                        (reqIdx == IR_SPEED_MEAS) ? measuredRpm : speedSetpoint_ff;

    // ------------------------------------------------------------
    // Setpoint source
    // ------------------------------------------------------------
    assign modeTemp = mode_ff == 16'h0000 || mode_ff == 16'h0005 ||
                      mode_ff == 16'h0008 || mode_ff == 16'h000B;
    assign setpointSel = (mode_ff == MODE_FIXED) ? fixedSpd_ff :
                         modeTemp ? volSp_ff : analogSetpoint;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BOOT_RD: nxt_state = ST_BOOT_WR;
            ST_BOOT_WR: nxt_state = (bootIdx_ff == BOOT_LAST) ? ST_IDLE : ST_BOOT_RD;
            ST_IDLE: nxt_state = readHoldOk ? ST_READ : ST_IDLE;
            ST_READ: nxt_state = ST_IDLE;
            default: nxt_state = ST_BOOT_RD;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_ff <= ST_BOOT_RD;
            bootIdx_ff <= 7'h00;
            reqReady_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bootIdx_ff <= bootWr ? bootIdx_ff + 7'h01 : bootIdx_ff;
            reqReady_ff <= nxt_state == ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Live shadow copies steering the drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            minRpm_ff <= MIN_RPM_DEF;
            maxRpm_ff <= MAX_RPM_DEF;
            skipLo_ff <= RST_SKIP;
            skipHi_ff <= RST_SKIP;
            fixedSpd_ff <= RST_ZERO;
            mode_ff <= RST_MODE;
            linkTmo_ff <= RST_ZERO;
            volSp_ff <= RST_ZERO;
        end
        else if (loadEn)
        begin
            if (loadIdx == HR_MIN_RPM) minRpm_ff <= loadWord;
            if (loadIdx == HR_MAX_RPM) maxRpm_ff <= loadWord;
            if (loadIdx == HR_SKIP_LO) skipLo_ff <= loadWord;
            if (loadIdx == HR_SKIP_HI) skipHi_ff <= loadWord;
            if (loadIdx == HR_FIXED_SPD) fixedSpd_ff <= loadWord;
            if (loadIdx == HR_MODE) mode_ff <= loadWord;
            if (loadIdx == HR_LINK_TMO) linkTmo_ff <= loadWord;
            if (loadIdx == HR_VOL_SP) volSp_ff <= loadWord;
        end
    end

    // ------------------------------------------------------------
    // Port settings
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rs485BitDiv_ff <= DIV_9600;
            rs485Framing_ff <= 2'h0;
            rs485Node_ff <= 8'h01;
            localBitDiv_ff <= DIV_57600;
            localFraming_ff <= LOCAL_FRAMING;
            localNode_ff <= LOCAL_NODE;
        end
        else
        begin
            if (loadEn && loadIdx == HR_BIT_RATE)
                rs485BitDiv_ff <= rateDiv;
            // Framing and node only follow the stored copy at boot
            if (bootWr && bootIdx_ff == HR_FRAMING)
                rs485Framing_ff <= bootWord[1:0];
            if (bootWr && bootIdx_ff == HR_NODE_ID)
                rs485Node_ff <= bootWord[7:0];
            localBitDiv_ff <= DIV_57600;
            localFraming_ff <= LOCAL_FRAMING;
            localNode_ff <= LOCAL_NODE;
        end
    end

    // ------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rspValid_ff <= 1'b0;
            rspException_ff <= 1'b0;
            rspPort_ff <= 1'b0;
            rspCode_ff <= 8'h00;
            rspData_ff <= 16'h0000;
            curPort_ff <= 1'b0;
        end
        else
        begin
            curPort_ff <= take ? reqPort : curPort_ff;
            rspValid_ff <= directRsp | (state_ff == ST_READ);
            if (state_ff == ST_READ)
            begin
                rspException_ff <= 1'b0;
                rspPort_ff <= curPort_ff;
                rspCode_ff <= FC_READ_HOLD;
                rspData_ff <= liveRdData;
            end
            else if (directRsp)
            begin
                rspException_ff <= directExc;
                rspPort_ff <= reqPort;
                rspCode_ff <= directExc ? (reqFunc | FC_EXC_FLAG) : reqFunc;
                rspData_ff <= directData;
            end
        end
    end

    // ------------------------------------------------------------
    // Drive controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            faultClear_ff <= 1'b0;
            fanStop_ff <= 1'b0;
            speedSetpoint_ff <= RST_ZERO;
            opMode_ff <= RST_MODE[3:0];
            switchKhz_ff <= KHZ_LOW_SPEED;
        end
        else
        begin
            faultClear_ff <= wrOk & (reqIdx == HR_RESET) & reqData[0];
            fanStop_ff <= linkExpired;
            speedSetpoint_ff <= setpointSel;
            opMode_ff <= mode_ff[3:0];
            // Lower switching rate at speed trades ripple for less heat
            switchKhz_ff <= (measuredRpm >= SWITCH_RPM) ? KHZ_HIGH_SPEED : KHZ_LOW_SPEED;
        end
    end

    // ------------------------------------------------------------
    // Storage and watch
    // ------------------------------------------------------------
    fdr_word_mem #(
        .WIDTH(16),
        .DEPTH(64)
    ) u_live (
        .clk_sys(clk_sys),
        .wrEn(loadEn & !loadIdx[6]),
        .wrAddr(loadIdx[5:0]),
        .wrData(loadWord),
        .rdAddr(reqIdx[5:0]),
        .rdData_ff(liveRdData)
    );

    // Stored image: survives reset, reloaded into the live copy at boot unless factoryRestore rewrites both with factory values
    fdr_word_mem #(
        .WIDTH(16),
        .DEPTH(64)
    ) u_stored (
        .clk_sys(clk_sys),
        .wrEn(nvmWrEn),
        .wrAddr(loadIdx[5:0]),
        .wrData(loadWord),
        .rdAddr(bootIdx_ff[5:0]),
        .rdData_ff(nvmRdData)
    );

    fdr_link_watch #(
        .CYC_PER_SEC(CYC_PER_SEC),
        .SEC_W(15)
    ) u_watch (
        .clk_sys(clk_sys),
        .srst(srst),
        .limitSec(linkTmo_ff[14:0]),
        .activity(take),
        .restart(faultClear_ff),
        .expired_ff(linkExpired)
    );
endmodule
`default_nettype wire

/* sim/fdr_holding_bank_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fdr_holding_bank_asserts
    import fdr_pkg::*;
#(
    parameter logic [15:0] SWITCH_RPM = 16'h03E8
)(
    input wire logic clk_sys, srst, reqValid, reqReady_ff, reqPort,
    input wire logic rspValid_ff, rspException_ff, faultClear_ff,
    input wire logic [7:0] reqNode, reqFunc, localNode_ff,
    input wire logic [15:0] reqReg, reqData, measuredRpm, rspData_ff,
    input wire logic [15:0] rs485BitDiv_ff, localBitDiv_ff,
    input wire logic [4:0] switchKhz_ff,
    input wire logic [1:0] localFraming_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Local port only: fixed node
    wire logic tk;
    wire logic wr;
    wire logic rd;
    assign tk = reqValid && reqReady_ff && reqPort && reqNode == 8'h01;
    assign wr = tk && reqFunc == FC_WRITE_ONE;
    assign rd = tk && reqFunc == FC_READ_HOLD;
    sequence rdRsp;
        !reqReady_ff ##1 rspValid_ff && !rspException_ff;
    endsequence
    sequence clrPulse;
        faultClear_ff ##1 !faultClear_ff;
    endsequence
    rd_timing_a: assert property (rd && reqReg == 16'h002F |=> rdRsp)
        else $error("read timing");
    wr_echo_a: assert property (wr && reqReg == 16'h0038 |=>
        rspValid_ff && !rspException_ff && rspData_ff == $past(reqData)) else $error("echo");
    clr_pulse_a: assert property (wr && reqReg == 16'h0000 && reqData == ONE |=> clrPulse)
        else $error("clear pulse");
    rate_now_a: assert property (wr && reqReg == 16'h002F && reqData == RATE_19200 |=>
        rs485BitDiv_ff == DIV_19200) else $error("rate");
    local_fixed_a: assert property (localBitDiv_ff == DIV_57600 && localNode_ff == LOCAL_NODE
        && localFraming_ff == LOCAL_FRAMING) else $error("local port");
    switch_freq_a: assert property ($stable(measuredRpm)[*3] ##0 reqReady_ff |-> switchKhz_ff ==
        (measuredRpm >= SWITCH_RPM ? KHZ_HIGH_SPEED : KHZ_LOW_SPEED)) else $error("switching");
    vol_read_a: assert property (rd && reqReg == 16'h0042 |=>
        rspValid_ff && rspException_ff && rspData_ff[7:0] == EXC_ADDR) else $error("vol read");
    bad_func_a: assert property (tk && reqFunc > FC_WRITE_ONE |=>
        rspException_ff && rspData_ff[7:0] == EXC_FUNC) else $error("bad function");
endmodule
bind fdr_holding_bank fdr_holding_bank_asserts #(.SWITCH_RPM(SWITCH_RPM)) u_chk (.clk_sys, .srst,
    .reqValid, .reqReady_ff, .reqPort, .rspValid_ff, .rspException_ff, .faultClear_ff, .reqNode,
    .reqFunc, .localNode_ff, .reqReg, .reqData, .measuredRpm, .rspData_ff, .rs485BitDiv_ff,
    .localBitDiv_ff, .switchKhz_ff, .localFraming_ff);
`default_nettype wire

/* sim/fdr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fdr_master_model (
    input wire logic clk_sys, reqReady_ff,
    output logic reqValid, reqPort,
    output logic [7:0] reqNode, reqFunc,
    output logic [15:0] reqReg, reqData
);
    initial {reqValid, reqPort, reqNode, reqFunc, reqReg, reqData} = '0;
    // Bad values go out only when a test hands them over
    task automatic send(input logic [48:0] fr, output bit ok);
        @(negedge clk_sys);
        {reqPort, reqNode, reqFunc, reqReg, reqData} = fr;
        reqValid = 1'b1;
        repeat (300)
        begin
            if (reqReady_ff) break;
            @(negedge clk_sys);
        end
        ok = reqReady_ff;
        @(negedge clk_sys);
        reqValid = 1'b0;
        reqData = ~reqData; // A released line never shows the last word
    endtask
endmodule
`default_nettype wire

/* sim/fdr_holding_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fdr_holding_bank_tb_top;
    import fdr_pkg::*;
    logic clk_sys = 0, srst = 1, factoryRestore = 1, motorRunning = 0, reqReady_ff, rspValid_ff;
    logic fanStop_ff;
    logic [15:0] rpm = 16'h0400;
    int errorCnt = 0, numChecks = 0;
    bit ok;
    wire logic reqValid, reqPort, rspException_ff;
    wire logic [7:0] reqNode, reqFunc, rs485Node_ff;
    wire logic [15:0] reqReg, reqData, rspData_ff, rs485BitDiv_ff;
    wire logic [1:0] rs485Framing_ff;
    logic [56:0] rows [11] = '{
        {8'h06, 16'h002F, RATE_19200, 1'b0, RATE_19200},
        {8'h06, 16'h002F, 16'h1234, 1'b1, 16'h0003},
        {8'h03, 16'h002F, 16'h0000, 1'b0, RATE_19200},
        {8'h06, 16'h0030, 16'h0003, 1'b1, 16'h0003},
        {8'h06, 16'h0030, 16'h0002, 1'b0, 16'h0002},
        {8'h06, 16'h002D, 16'h00F8, 1'b1, 16'h0003},
        {8'h06, 16'h0000, 16'h0001, 1'b0, 16'h0001},
        {8'h03, 16'h0000, 16'h0000, 1'b0, 16'h0000},
        {8'h03, 16'h0042, 16'h0000, 1'b1, 16'h0002},
        {8'h04, 16'h0003, 16'h0000, 1'b0, 16'h0400},
        {8'h10, 16'h0022, 16'h0000, 1'b1, 16'h0001}};
    initial forever #5 clk_sys = ~clk_sys;
    fdr_master_model i_mst (.clk_sys, .reqReady_ff, .reqValid, .reqPort, .reqNode, .reqFunc,
        .reqReg, .reqData);
    fdr_holding_bank #(.CYC_PER_SEC(4)) i_dut (.clk_sys, .srst, .factoryRestore, .reqValid,
        .reqPort, .reqNode, .reqFunc, .reqReg, .reqData, .motorRunning, .measuredRpm(rpm),
        .analogSetpoint(16'h0000), .reqReady_ff, .rspValid_ff, .rspException_ff, .rspPort_ff(),
        .rspCode_ff(), .rspData_ff, .faultClear_ff(), .fanStop_ff, .speedSetpoint_ff(),
        .opMode_ff(), .switchKhz_ff(), .rs485BitDiv_ff, .rs485Framing_ff, .rs485Node_ff,
        .localBitDiv_ff(), .localFraming_ff(), .localNode_ff());
    task automatic printVerdict;
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        numChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic waitFor(input int n, ref logic s);
        repeat (n)
        begin
            if (s === 1'b1) break;
            @(negedge clk_sys);
        end
        if (s !== 1'b1)
        begin
            errorCnt++;
            printVerdict();
        end
    endtask
    task automatic boot;
        srst = 1'b1;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        waitFor(200, reqReady_ff);
    endtask
    task automatic xfer(input logic [48:0] fr, input logic [16:0] ex);
        i_mst.send(fr, ok);
        waitFor(4, rspValid_ff);
        chk("exception", {15'h0000, ex[16]}, {15'h0000, rspException_ff});
        chk("data", ex[15:0], ex[16] ? {8'h00, rspData_ff[7:0]} : rspData_ff);
    endtask
    initial
    begin
        boot();
        chk("rate", DIV_9600, rs485BitDiv_ff);
        chk("node", 16'h0001, {8'h00, rs485Node_ff});
        for (int i = 0; i < 11; i++) xfer({9'h101, rows[i][56:17]}, rows[i][16:0]);
        chk("rate", DIV_19200, rs485BitDiv_ff);
        chk("framing", 16'h0000, {14'h0000, rs485Framing_ff});
        i_mst.send({9'h000, 8'h06, 16'h002F, RATE_9600}, ok);
        rpm = 16'h0100;
        chk("broadcast", DIV_9600, rs485BitDiv_ff);
        motorRunning = 1'b1;
        xfer({9'h101, 8'h06, 16'h002D, 16'h0005}, {1'b0, 16'h0005});
        motorRunning = 1'b0;
        xfer({9'h101, 8'h06, 16'h0038, 16'h0001}, {1'b0, 16'h0001});
        waitFor(20, fanStop_ff);
        factoryRestore = 1'b0;
        boot();
        chk("framing", 16'h0002, {14'h0000, rs485Framing_ff});
        chk("node", 16'h0001, {8'h00, rs485Node_ff});
        chk("rate", DIV_9600, rs485BitDiv_ff);
        printVerdict();
    end
endmodule
`default_nettype wire
